// ### hw/dpr_pkg.sv
// package: dual-port ram configuration, carriers and init helpers
package dpr_pkg;

  localparam int DPR_WA   = 8;
  localparam int DPR_WB   = 16;
  localparam int DPR_FF   = DPR_WB / DPR_WA;
  localparam int DPR_FFB  = $clog2(DPR_FF);
  localparam int DPR_DA   = 64;
  localparam int DPR_DB   = DPR_DA / DPR_FF;
  localparam int DPR_AWA  = $clog2(DPR_DA);
  localparam int DPR_AWB  = $clog2(DPR_DB);
  localparam int DPR_LAT  = 1;
  // init figures are fixed point with this many fraction bits
  localparam int DPR_FRAC = 2;

  typedef enum logic [2:0] {
    DPR_RAW = 3'h1,
    DPR_RBW = 3'h2,
    DPR_NRW = 3'h4
  } dpr_mode_t;

  typedef enum logic [2:0] {
    DPR_DIST  = 3'h1,
    DPR_BRAM  = 3'h2,
    DPR_DENSE = 3'h4
  } dpr_mem_t;

  localparam dpr_mem_t  DPR_MEM_TYPE = DPR_BRAM;
  localparam dpr_mode_t DPR_MODE_A   = DPR_RAW;
  localparam dpr_mode_t DPR_MODE_B   = DPR_RBW;

  localparam int DPR_INIT_LEN = 6;
  localparam int DPR_INIT_VEC [DPR_INIT_LEN] = '{20, -4, 1023, 6, 2000, 9};
  localparam int DPR_OUT_INIT_A = 30;
  localparam int DPR_OUT_INIT_B = -5;

  typedef struct packed {
    logic               en;
    logic               we;
    logic [DPR_AWA-1:0] addr;
    logic [DPR_WA-1:0]  wdata;
  } dpr_a_req_t;

  typedef struct packed {
    logic               en;
    logic               we;
    logic [DPR_AWB-1:0] addr;
    logic [DPR_WB-1:0]  wdata;
  } dpr_b_req_t;

  typedef struct packed {
    logic              valid;
    logic [DPR_WA-1:0] data;
  } dpr_a_rsp_t;

  typedef struct packed {
    logic              valid;
    logic [DPR_WB-1:0] data;
  } dpr_b_rsp_t;

  // round half up, then clamp to the unsigned range of w bits
  function automatic int dpr_sat_round(int v, int w);
    int r;
    r = (v + (1 << (DPR_FRAC - 1))) >>> DPR_FRAC;
    if (r < 0) r = 0;
    if (r > (1 << w) - 1) r = (1 << w) - 1;
    return r;
  endfunction

  function automatic logic [DPR_WA-1:0] dpr_init_word(int i);
    logic [DPR_WA-1:0] r;
    r = '0;
    if (i < DPR_INIT_LEN) r = DPR_WA'(dpr_sat_round(DPR_INIT_VEC[i], DPR_WA));
    return r;
  endfunction

  localparam logic [DPR_WA-1:0] DPR_RST_A = DPR_WA'(dpr_sat_round(DPR_OUT_INIT_A, DPR_WA));
  localparam logic [DPR_WB-1:0] DPR_RST_B = DPR_WB'(dpr_sat_round(DPR_OUT_INIT_B, DPR_WB));

endpackage

// ### hw/dpr_out_reg.sv
// output register of one ram port: enable, sync reset, valid flag
`timescale 1ns/1ps
module dpr_out_reg
  import dpr_pkg::*;
#(
  parameter int           W    = 8,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         srst_in,
  input  wire logic         cap_in,
  input  wire logic         valid_d_in,
  input  wire logic [W-1:0] data_d_in,
  output logic              valid_out,
  output logic [W-1:0]      data_out
);

  typedef struct packed {
    logic         valid;
    logic [W-1:0] data;
  } dpr_oreg_st_t;

  dpr_oreg_st_t st_q;
  dpr_oreg_st_t st_d;

  always_comb begin
    st_d = st_q;
    // sync reset wins over the port enable
    if (sys_rst_in || srst_in) begin
      st_d.valid = 1'b1;
      st_d.data  = INIT;
    end else if (cap_in) begin
      st_d.valid = valid_d_in;
      st_d.data  = data_d_in;
    end
  end

  always_ff @(posedge clk_in) begin
    st_q <= st_d;
  end

  assign valid_out = st_q.valid;
  assign data_out  = st_q.data;

endmodule // dpr_out_reg

// ### hw/dpr_ram.sv
// true dual-port ram except on distributed memory, where port b is read-only; port b a multiple of port a in width
`timescale 1ns/1ps
module dpr_ram
  import dpr_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire dpr_a_req_t port_a_in,
  input  wire dpr_b_req_t port_b_in,
  input  wire logic       srst_a_in,
  input  wire logic       srst_b_in,
  output dpr_a_rsp_t      rsp_a_out,
  output dpr_b_rsp_t      rsp_b_out
);

  typedef struct packed {
    logic [DPR_DA-1:0][DPR_WA-1:0] mem;
  } dpr_st_t;

  dpr_st_t st_q;
  dpr_st_t st_d;

  // distributed memory forces port a mode; block memory uses the setting
  localparam dpr_mode_t MODE_A = (DPR_MEM_TYPE == DPR_DIST) ? DPR_RBW : DPR_MODE_A;
  localparam dpr_mode_t MODE_B = DPR_MODE_B;
  localparam logic      B_RO   = (DPR_MEM_TYPE == DPR_DIST);
  localparam logic      DENSE  = (DPR_MEM_TYPE == DPR_DENSE);

  // enable and sync reset exist only with a registered output
  localparam logic HAS_PORT_CTL = (DPR_LAT >= 1);

  logic              en_a;
  logic              en_b;
  logic              srst_a;
  logic              srst_b;
  logic              wa;
  logic              wb;
  logic              ovl;
  logic              ww;
  logic [DPR_WA-1:0] old_a;
  logic [DPR_WB-1:0] old_b;
  logic              cap_a;
  logic              cap_b;
  logic              vld_a_d;
  logic              vld_b_d;
  logic [DPR_WA-1:0] dat_a_d;
  logic [DPR_WB-1:0] dat_b_d;

  // without latency the enables are forced on and resets off
  assign en_a   = HAS_PORT_CTL ? port_a_in.en : 1'b1;
  assign en_b   = HAS_PORT_CTL ? port_b_in.en : 1'b1;
  assign srst_a = HAS_PORT_CTL & srst_a_in;
  assign srst_b = HAS_PORT_CTL & srst_b_in;

  assign wa = en_a & port_a_in.we;
  assign wb = en_b & port_b_in.we & ~B_RO;

  // a port-b word spans DPR_FF port-a words; upper a bits pick the word
  assign ovl = (port_a_in.addr[DPR_AWA-1:DPR_FFB] == port_b_in.addr);
  assign ww  = wa & wb & ovl;

  always_comb begin
    logic [DPR_AWA-1:0] idx;
    idx     = '0;
    st_d    = st_q;
    old_a   = st_q.mem[port_a_in.addr];
    old_b   = '0;
    for (int k = 0; k < DPR_FF; k++) begin
      idx = {port_b_in.addr, DPR_FFB'(k)};
      old_b[k*DPR_WA +: DPR_WA] = st_q.mem[idx];
    end

    // stored contents only change by the writers or the system reset, never by a read
    if (wa) begin
      st_d.mem[port_a_in.addr] = port_a_in.wdata;
    end
    // on a write-write clash b lands last; outputs are invalid anyway
    if (wb) begin
      for (int k = 0; k < DPR_FF; k++) begin
        idx = {port_b_in.addr, DPR_FFB'(k)};
        st_d.mem[idx] = port_b_in.wdata[k*DPR_WA +: DPR_WA];
      end
    end

    // loop runs over the ram only, so surplus init entries never land
    if (sys_rst_in) begin
      for (int i = 0; i < DPR_DA; i++) begin
        st_d.mem[i] = DENSE ? '0 : dpr_init_word(i);
      end
    end

    // port a output path
    cap_a   = en_a & ~(wa & (MODE_A == DPR_NRW));
    dat_a_d = (wa && MODE_A == DPR_RAW) ? port_a_in.wdata : old_a;
    vld_a_d = 1'b1;
    if (ww) vld_a_d = 1'b0;
    if (wb && ovl && !wa && MODE_B != DPR_RBW) vld_a_d = 1'b0;

    // port b output path
    cap_b   = en_b & ~(wb & (MODE_B == DPR_NRW));
    dat_b_d = (wb && MODE_B == DPR_RAW) ? port_b_in.wdata : old_b;
    vld_b_d = 1'b1;
    if (ww) vld_b_d = 1'b0;
    if (wa && ovl && !wb && MODE_A != DPR_RBW) vld_b_d = 1'b0;
  end

  always_ff @(posedge clk_in) begin
    st_q <= st_d;
  end

  dpr_out_reg #(
    .W    (DPR_WA),
    .INIT (DPR_RST_A)
  ) u_out_a (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .srst_in    (srst_a),
    .cap_in     (cap_a),
    .valid_d_in (vld_a_d),
    .data_d_in  (dat_a_d),
    .valid_out  (rsp_a_out.valid),
    .data_out   (rsp_a_out.data)
  );

  dpr_out_reg #(
    .W    (DPR_WB),
    .INIT (DPR_RST_B)
  ) u_out_b (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .srst_in    (srst_b),
    .cap_in     (cap_b),
    .valid_d_in (vld_b_d),
    .data_d_in  (dat_b_d),
    .valid_out  (rsp_b_out.valid),
    .data_out   (rsp_b_out.data)
  );

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_a_wr;
    wa && !wb && !srst_a;
  endsequence

  sequence s_b_rd;
    en_b && !port_b_in.we && !srst_b;
  endsequence

  sequence s_a_rd;
    en_a && !port_a_in.we && !srst_a;
  endsequence

  sequence s_b_wr;
    wb && !wa && !srst_b;
  endsequence

  sequence s_ww;
    ww && !srst_a && !srst_b;
  endsequence

  sequence s_rd_pair;
    s_a_rd ##0 s_b_rd ##0 ovl;
  endsequence

  a_ww_invalid: assert property (
    ww && !srst_a && !srst_b |=> !rsp_a_out.valid && !rsp_b_out.valid
  ) else $error("write-write clash left an output valid");

  a_wr_intact: assert property (
    s_a_wr ##0 s_b_rd ##0 ovl |=> st_q.mem[$past(port_a_in.addr)] == $past(port_a_in.wdata)
  ) else $error("write-read clash corrupted stored word");

  a_rbw_old: assert property (
    s_a_wr ##0 s_b_rd ##0 (ovl && MODE_A == DPR_RBW)
      |=> rsp_b_out.valid && rsp_b_out.data == $past(old_b)
  ) else $error("reader did not get old contents");

  a_raw_bad: assert property (
    s_b_wr ##0 s_a_rd ##0 (ovl && MODE_B != DPR_RBW) |=> !rsp_a_out.valid
  ) else $error("clash read not flagged invalid");

  a_depth_ratio: assert property (
    sys_rst_in || (DPR_DB * DPR_FF == DPR_DA && DPR_WB == DPR_WA * DPR_FF)
  ) else $error("port b depth does not match width ratio");

  a_zero_tail: assert property (
    disable iff (1'b0)
    sys_rst_in ##1 !sys_rst_in |-> st_q.mem[DPR_DA-1] == '0
  ) else $error("trailing word not cleared");

  a_init_round: assert property (
    disable iff (1'b0)
    sys_rst_in |=> st_q.mem[2] == (DENSE ? '0 : DPR_WA'(dpr_sat_round(DPR_INIT_VEC[2], DPR_WA)))
  ) else $error("init word not saturated and rounded");

  a_dist_ro: assert property (
    (B_RO && en_b && port_b_in.we && !wa) |=> $stable(st_q.mem)
  ) else $error("read-only port changed memory");

  a_raw_own: assert property (
    s_a_wr ##0 (MODE_A == DPR_RAW) |=> rsp_a_out.data == $past(port_a_in.wdata) && rsp_a_out.valid
  ) else $error("own read after write not new data");

  a_rbw_own: assert property (
    s_a_wr ##0 (MODE_A == DPR_RBW) |=> rsp_a_out.data == $past(old_a)
  ) else $error("own read before write not old data");

  a_nrw_hold: assert property (
    s_a_wr ##0 (MODE_A == DPR_NRW) |=> $stable(rsp_a_out)
  ) else $error("no-read-on-write output moved");

  a_write_store: assert property (
    s_b_wr ##1 (!wa && !wb) [*2] |-> st_q.mem[{$past(port_b_in.addr, 2), DPR_FFB'(0)}]
      == $past(port_b_in.wdata[DPR_WA-1:0], 2)
  ) else $error("port b write not stored");

  a_read_show: assert property (
    s_a_rd ##0 !wb |=> rsp_a_out.data == $past(old_a) && rsp_a_out.valid
  ) else $error("read did not show addressed word");

  a_rr_ok: assert property (
    s_a_rd ##0 s_b_rd ##0 ovl |=> rsp_a_out.valid && rsp_b_out.valid
      && rsp_b_out.data[DPR_WA-1:0] == $past(st_q.mem[{port_b_in.addr, DPR_FFB'(0)}])
  ) else $error("read-read clash failed");

  a_srst_init: assert property (
    srst_a |=> rsp_a_out.data == DPR_RST_A && rsp_a_out.valid ##0 $past(srst_a)
  ) else $error("sync reset did not load initial value");

  a_en_hold: assert property (
    !en_a && !srst_a |=> $stable(rsp_a_out)
  ) else $error("disabled port output moved");

  // port b side of the checks, mixed with further port a and memory checks; the two ports carry different write modes
  a_ww_b_wins: assert property (
    s_ww |=> st_q.mem[{$past(port_b_in.addr), DPR_FFB'(0)}] == $past(port_b_in.wdata[DPR_WA-1:0])
  ) else $error("write-write clash lost port b data");

  a_wr_intact_b: assert property (
    s_b_wr ##0 s_a_rd ##0 ovl |=> st_q.mem[{$past(port_b_in.addr), DPR_FFB'(1)}]
      == $past(port_b_in.wdata[2*DPR_WA-1:DPR_WA])
  ) else $error("read-write clash corrupted port b word");

  a_rbw_old_b: assert property (
    s_b_wr ##0 s_a_rd ##0 (ovl && MODE_B == DPR_RBW)
      |=> rsp_a_out.valid && rsp_a_out.data == $past(old_a)
  ) else $error("port a reader did not get old contents");

  a_raw_bad_b: assert property (
    s_a_wr ##0 s_b_rd ##0 (ovl && MODE_A != DPR_RBW) |=> !rsp_b_out.valid
  ) else $error("port b clash read not flagged invalid");

  a_rbw_own_b: assert property (
    s_b_wr ##0 (MODE_B == DPR_RBW) |=> rsp_b_out.data == $past(old_b)
  ) else $error("port b read before write not old data");

  a_raw_own_b: assert property (
    s_b_wr ##0 (MODE_B == DPR_RAW) |=> rsp_b_out.data == $past(port_b_in.wdata) && rsp_b_out.valid
  ) else $error("port b read after write not new data");

  a_nrw_hold_b: assert property (
    s_b_wr ##0 (MODE_B == DPR_NRW) |=> $stable(rsp_b_out)
  ) else $error("port b no-read-on-write output moved");

  a_read_show_b: assert property (
    s_b_rd ##0 !wa |=> rsp_b_out.data == $past(old_b) && rsp_b_out.valid
  ) else $error("port b read did not show addressed word");

  a_write_a: assert property (
    s_a_wr |=> st_q.mem[$past(port_a_in.addr)] == $past(port_a_in.wdata)
  ) else $error("port a write not stored");

  a_srst_b_init: assert property (
    srst_b |=> rsp_b_out.data == DPR_RST_B && rsp_b_out.valid
  ) else $error("port b sync reset did not load initial value");

  a_en_hold_b: assert property (
    !en_b && !srst_b |=> $stable(rsp_b_out)
  ) else $error("disabled port b output moved");

  a_no_stray_write: assert property (
    !(port_a_in.en && port_a_in.we) && !(port_b_in.en && port_b_in.we) |=> $stable(st_q.mem)
  ) else $error("memory changed without a write");

  a_rst_out_a: assert property (
    disable iff (1'b0)
    sys_rst_in |=> rsp_a_out.data == DPR_RST_A && rsp_a_out.valid
  ) else $error("port a output not at initial value after reset");

  a_rst_out_b: assert property (
    disable iff (1'b0)
    sys_rst_in |=> rsp_b_out.data == DPR_RST_B && rsp_b_out.valid
  ) else $error("port b output not at initial value after reset");

  a_init_head: assert property (
    disable iff (1'b0)
    sys_rst_in |=> st_q.mem[0] == (DENSE ? '0 : dpr_init_word(0))
  ) else $error("first init word not loaded");

  a_tail_after: assert property (
    disable iff (1'b0)
    sys_rst_in |=> st_q.mem[DPR_INIT_LEN] == '0
  ) else $error("first word past init vector not zero");

  a_rr_hi: assert property (
    s_rd_pair |=> rsp_b_out.data[2*DPR_WA-1:DPR_WA]
      == $past(st_q.mem[{port_b_in.addr, DPR_FFB'(1)}])
  ) else $error("read-read clash high byte wrong");

  a_write_b_hi: assert property (
    s_b_wr |=> st_q.mem[{$past(port_b_in.addr), DPR_FFB'(1)}]
      == $past(port_b_in.wdata[2*DPR_WA-1:DPR_WA])
  ) else $error("port b high byte not stored");

  a_rr_a: assert property (
    s_rd_pair |=> rsp_a_out.data == $past(old_a) && rsp_a_out.valid
  ) else $error("read-read clash port a word wrong");

endmodule // dpr_ram

// ### dv/dpr_user.sv
// partner model: user logic driving both ram ports
`timescale 1ns/1ps
module dpr_user
  import dpr_pkg::*;
(
  input  wire logic  clk_in,
  output dpr_a_req_t port_a_out,
  output dpr_b_req_t port_b_out,
  output logic       srst_a_out,
  output logic       srst_b_out
);
  initial begin
    port_a_out = '0;
    port_b_out = '0;
    srst_a_out = 1'b0;
    srst_b_out = 1'b0;
  end

  // one access cycle on both ports; address widths are log2 of the depths, so no
  // address past the end can be formed
  task automatic drive(input dpr_a_req_t a, input dpr_b_req_t b, input logic ra, input logic rb);
    @(negedge clk_in);
    port_a_out = a;
    port_b_out = b;
    srst_a_out = ra;
    srst_b_out = rb;
    @(posedge clk_in);
    @(negedge clk_in);
    // released address and data lines show the inverse, not a stale copy
    port_a_out.en    = 1'b0;
    port_a_out.we    = 1'b0;
    port_a_out.addr  = ~a.addr;
    port_a_out.wdata = ~a.wdata;
    port_b_out.en    = 1'b0;
    port_b_out.we    = 1'b0;
    port_b_out.addr  = ~b.addr;
    port_b_out.wdata = ~b.wdata;
    srst_a_out = 1'b0;
    srst_b_out = 1'b0;
  endtask
endmodule // dpr_user

// ### dv/dual_port_ram_block_test.sv
// testbench: dual-port ram driven through the partner model
`timescale 1ns/1ps
module dual_port_ram_block_test;
  import dpr_pkg::*;
  logic       clk_in;
  logic       sys_rst_in;
  dpr_a_req_t a_req;
  dpr_b_req_t b_req;
  logic       srst_a;
  logic       srst_b;
  dpr_a_rsp_t rsp_a;
  dpr_b_rsp_t rsp_b;
  int         fails;
  int         tests_run;
  logic [7:0] init_a [8];

  dpr_user u_user (
    .clk_in    (clk_in),
    .port_a_out(a_req),
    .port_b_out(b_req),
    .srst_a_out(srst_a),
    .srst_b_out(srst_b)
  );

  dpr_ram DUT (
    .clk_in    (clk_in),
    .sys_rst_in(sys_rst_in),
    .port_a_in (a_req),
    .port_b_in (b_req),
    .srst_a_in (srst_a),
    .srst_b_in (srst_b),
    .rsp_a_out (rsp_a),
    .rsp_b_out (rsp_b)
  );

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  function automatic dpr_a_req_t ra(logic e, logic w, int ad, logic [7:0] d);
    return '{e, w, DPR_AWA'(ad), d};
  endfunction

  function automatic dpr_b_req_t rb(logic e, logic w, int ad, logic [15:0] d);
    return '{e, w, DPR_AWB'(ad), d};
  endfunction

  task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_ab(input logic [8:0] ea, input logic [16:0] eb);
    chk("port a response", 17'(ea), 17'(rsp_a));
    chk("port b response", eb, 17'(rsp_b));
  endtask

  task automatic tally_and_finish;
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #(25 * 2000);
    fails++;
    tally_and_finish();
  end

  initial begin
    fails      = 0;
    tests_run  = 0;
    sys_rst_in = 1'b1;
    // expected words: quarter units rounded half up, clamped to 8 bits
    init_a = '{8'h05, 8'h00, 8'hff, 8'h02, 8'hff, 8'h02, 8'h00, 8'h00};
    repeat (12) @(negedge clk_in);
    sys_rst_in = 1'b0;
    chk_ab({1'b1, 8'h08}, {1'b1, 16'h0000});
    for (int i = 0; i < 8; i++) begin
      u_user.drive(ra(1, 0, i, 8'h00), rb(1, 0, i / 2, 16'h0000), 0, 0);
      chk_ab({1'b1, init_a[i]}, {1'b1, init_a[i | 1], init_a[i & 6]});
    end
    // a writes in read-after-write while b reads the same word
    u_user.drive(ra(1, 1, 3, 8'h5a), rb(1, 0, 1, 16'h0000), 0, 0);
    chk("port a write output", 17'({1'b1, 8'h5a}), 17'(rsp_a));
    chk("port b collided valid", 17'(1'b0), 17'(rsp_b.valid));
    u_user.drive(ra(1, 0, 3, 8'h00), rb(1, 0, 1, 16'h0000), 0, 0);
    chk_ab({1'b1, 8'h5a}, {1'b1, 16'h5aff});
    // b writes in read-before-write while a reads the same word
    u_user.drive(ra(1, 0, 4, 8'h00), rb(1, 1, 2, 16'h1234), 0, 0);
    chk_ab({1'b1, 8'hff}, {1'b1, 16'h02ff});
    u_user.drive(ra(1, 0, 5, 8'h00), rb(1, 0, 2, 16'h0000), 0, 0);
    chk_ab({1'b1, 8'h12}, {1'b1, 16'h1234});
    // both ports write one word in the same cycle
    u_user.drive(ra(1, 1, 6, 8'h11), rb(1, 1, 3, 16'habcd), 0, 0);
    chk("both valid flags", 17'(2'b00), 17'({rsp_a.valid, rsp_b.valid}));
    u_user.drive(ra(1, 0, 6, 8'h00), rb(1, 0, 3, 16'h0000), 0, 0);
    chk_ab({1'b1, 8'hcd}, {1'b1, 16'habcd});
    // disabled ports neither write nor update their outputs
    u_user.drive(ra(0, 1, 7, 8'h77), rb(0, 1, 3, 16'h5555), 0, 0);
    chk_ab({1'b1, 8'hcd}, {1'b1, 16'habcd});
    u_user.drive(ra(1, 0, 7, 8'h00), rb(1, 0, 3, 16'h0000), 0, 0);
    chk_ab({1'b1, 8'hab}, {1'b1, 16'habcd});
    // output resets beat an enabled read
    u_user.drive(ra(1, 0, 2, 8'h00), rb(1, 0, 1, 16'h0000), 1, 1);
    chk_ab({1'b1, 8'h08}, {1'b1, 16'h0000});
    tally_and_finish();
  end
endmodule // dual_port_ram_block_test
